/* File: verilog/rx_straddle_stream.sv */
// Receive two-segment straddle stream output stage with frame checking
//
// Contract
// - All client signals launch and sample on the stream clock rising edge.
// - Receive reset is active high, synchronous; held until clock is stable.
// - Transmit reset is active high, synchronous; handled outside this block.
// - Frames leave on a 128-bit straddle bus; two frames may share a word.
// - A 256-bit plain bus is an alternative at 40 Gb/s only.
// - Every output is timed to the receive clock rising edge.
// - Frame bytes leave on a 128-bit data bus, bits 127 down to 0.
// - Word valid is high exactly when the data bus carries frame data.
// - Each segment flags the cycle carrying the first data of a frame.
// - Each segment flags the cycle carrying the last data of a frame.
// - Each segment bad flag is 1 for a bad ending frame, else 0.
// - Each segment reports unused bytes of the final transfer on three bits.
// - Each segment enable is high whenever its half carries frame data.
// - Once a frame starts, its words follow on consecutive cycles; here a source starving mid-frame can still gap it.
// - Non-final transfers keep all bytes valid and empty count zero.
// - Bad on check sequence mismatch, length out of range, or code error.
`default_nettype none
module rx_straddle_stream (
  input  wire logic                               i_clk,
  input  wire logic                               i_rst,
  // Upstream receive datapath, same clock
  input  wire logic [rx_stream_pkg::DATA_W-1:0]    i_word_data,
  input  wire logic                               i_word_valid,
  input  wire logic [rx_stream_pkg::SEG_COUNT-1:0] i_seg_enable,
  input  wire logic [rx_stream_pkg::SEG_COUNT-1:0] i_seg_start,
  input  wire logic [rx_stream_pkg::SEG_COUNT-1:0] i_seg_end,
  input  wire logic [rx_stream_pkg::MTY_W-1:0]     i_seg0_empty,
  input  wire logic [rx_stream_pkg::MTY_W-1:0]     i_seg1_empty,
  input  wire logic [rx_stream_pkg::SEG_COUNT-1:0] i_seg_fcs_bad,
  input  wire logic [rx_stream_pkg::SEG_COUNT-1:0] i_seg_code_bad,
  output logic                                    o_in_ready,
  // Client straddle stream
  output logic [rx_stream_pkg::DATA_W-1:0]         o_rx_data,
  output logic                                    o_rx_valid,
  output logic                                    o_segment0_enable,
  output logic                                    o_segment1_enable,
  output logic                                    o_segment0_frame_start,
  output logic                                    o_segment1_frame_start,
  output logic                                    o_segment0_frame_end,
  output logic                                    o_segment1_frame_end,
  output logic                                    o_segment0_frame_bad,
  output logic                                    o_segment1_frame_bad,
  output logic [rx_stream_pkg::MTY_W-1:0]          o_segment0_empty_bytes,
  output logic [rx_stream_pkg::MTY_W-1:0]          o_segment1_empty_bytes
);
  import rx_stream_pkg::*;

  // Only the 128-bit straddle form is built here
  // Transmit reset serves the transmit path, not this block

  // ==========================================================================
  // Buffer carriers
  word_stream_if #(.WIDTH(WORD_W)) fill_bus ();
  word_stream_if #(.WIDTH(WORD_W)) drain_bus ();

  word_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_buffer (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .fill_side  (fill_bus),
    .drain_side (drain_bus)
  );

  // ==========================================================================
  // Frame checking on the fill side
  logic [LEN_W-1:0]     frame_len;
  logic                 code_sticky;
  logic [LEN_W-1:0]     next_frame_len;
  logic                 next_code_sticky;
  logic [SEG_COUNT-1:0] push_err;
  logic [MTY_W-1:0]     push_mty [SEG_COUNT];
  logic [MTY_W-1:0]     in_mty   [SEG_COUNT];
  logic                 accept;

  assign in_mty[0] = i_seg0_empty;
  assign in_mty[1] = i_seg1_empty;
  assign accept    = fill_bus.valid && fill_bus.ready;

  // Length test of a finished frame
  function automatic logic length_bad(input logic [LEN_W-1:0] total,
                                      input logic [MTY_W-1:0] empty);
    logic [LEN_W-1:0] bytes;
    bytes      = LEN_W'(total - LEN_W'(empty));
    length_bad = (bytes < MIN_FRAME_BYTES) || (bytes > MAX_FRAME_BYTES);
  endfunction

  // Segment 0 is older than segment 1, so walk them in order
  always_comb begin
    next_frame_len   = frame_len;
    next_code_sticky = code_sticky;
    push_err         = '0;
    for (int s = 0; s < SEG_COUNT; s++) begin
      push_mty[s] = MTY_RESET;
      if (accept && i_seg_enable[s]) begin
        if (i_seg_start[s]) begin
          next_frame_len   = '0;
          next_code_sticky = 1'b0;
        end
        // Saturate so giant frames stay flagged as too long
        if (next_frame_len < LEN_SATURATE) begin
          next_frame_len = LEN_W'(next_frame_len + SEG_BYTES_LEN);
        end
        next_code_sticky = next_code_sticky | i_seg_code_bad[s];
        if (i_seg_end[s]) begin
          push_mty[s] = in_mty[s];
          push_err[s] = i_seg_fcs_bad[s] || next_code_sticky ||
                        length_bad(next_frame_len, in_mty[s]);
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      frame_len   <= '0;
      code_sticky <= 1'b0;
    end else begin
      frame_len   <= next_frame_len;
      code_sticky <= next_code_sticky;
    end
  end

  // Pack one buffered word; empty count forced to zero unless the frame ends
  assign fill_bus.valid = i_word_valid && (i_seg_enable != '0); // Empty words dropped
  assign fill_bus.data  = {push_mty[1], push_mty[0], push_err,
                           i_seg_end & i_seg_enable, i_seg_start & i_seg_enable,
                           i_seg_enable, i_word_data};
  assign o_in_ready     = fill_bus.ready;

  // ==========================================================================
  // Drain sequencer
  drain_state_t         state;
  drain_state_t         next_state;
  logic [4:0]           frames_held;
  logic [4:0]           next_frames_held;
  logic                 push_has_end;
  logic                 pop_has_end;
  logic                 pop_fire;

  assign push_has_end    = accept && ((i_seg_end & i_seg_enable) != '0);
  assign pop_fire        = drain_bus.valid && drain_bus.ready;
  assign pop_has_end     = pop_fire && (drain_bus.data[POS_EOP +: SEG_COUNT] != '0);
  assign drain_bus.ready = (state == DRAIN_RUN);

  // Draining waits for a whole frame end or a full buffer, so that a frame
  // normally leaves without gaps; a source starving mid-frame still can gap
  always_comb begin
    next_frames_held = 5'(frames_held + 5'(push_has_end) - 5'(pop_has_end));
    next_state       = state;
    unique case (state)
      DRAIN_WAIT: begin
        if ((frames_held != '0) || !fill_bus.ready) begin
          next_state = DRAIN_RUN;
        end
      end
      DRAIN_RUN: begin
        if (!drain_bus.valid) begin
          next_state = DRAIN_WAIT;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state       <= DRAIN_WAIT;
      frames_held <= FRAMES_RESET;
    end else begin
      state       <= next_state;
      frames_held <= next_frames_held;
    end
  end

  // ==========================================================================
  // Client output registers; no client stall exists, every pop goes out
  logic [DATA_W-1:0]    out_data;
  logic                 out_valid;
  logic [SEG_COUNT-1:0] out_en;
  logic [SEG_COUNT-1:0] out_sop;
  logic [SEG_COUNT-1:0] out_eop;
  logic [SEG_COUNT-1:0] out_err;
  logic [MTY_W-1:0]     out_mty0;
  logic [MTY_W-1:0]     out_mty1;
  logic [DATA_W-1:0]    next_out_data;
  logic                 next_out_valid;
  logic [SEG_COUNT-1:0] next_out_en;
  logic [SEG_COUNT-1:0] next_out_sop;
  logic [SEG_COUNT-1:0] next_out_eop;
  logic [SEG_COUNT-1:0] next_out_err;
  logic [MTY_W-1:0]     next_out_mty0;
  logic [MTY_W-1:0]     next_out_mty1;

  // Idle cycles drive all qualifiers low
  always_comb begin
    next_out_valid = 1'b0;
    next_out_data  = '0;
    next_out_en    = '0;
    next_out_sop   = '0;
    next_out_eop   = '0;
    next_out_err   = '0;
    next_out_mty0  = MTY_RESET;
    next_out_mty1  = MTY_RESET;
    if (pop_fire) begin
      next_out_valid = 1'b1;
      next_out_data  = drain_bus.data[POS_DATA +: DATA_W];
      next_out_en    = drain_bus.data[POS_EN +: SEG_COUNT];
      next_out_sop   = drain_bus.data[POS_SOP +: SEG_COUNT];
      next_out_eop   = drain_bus.data[POS_EOP +: SEG_COUNT];
      next_out_err   = drain_bus.data[POS_ERR +: SEG_COUNT];
      next_out_mty0  = drain_bus.data[POS_MTY +: MTY_W];
      next_out_mty1  = drain_bus.data[POS_MTY + MTY_W +: MTY_W];
    end
  end

  // Launched on the rising edge, reset synchronously
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      out_valid <= 1'b0;
      out_data  <= '0;
      out_en    <= '0;
      out_sop   <= '0;
      out_eop   <= '0;
      out_err   <= '0;
      out_mty0  <= MTY_RESET;
      out_mty1  <= MTY_RESET;
    end else begin
      out_valid <= next_out_valid;
      out_data  <= next_out_data;
      out_en    <= next_out_en;
      out_sop   <= next_out_sop;
      out_eop   <= next_out_eop;
      out_err   <= next_out_err;
      out_mty0  <= next_out_mty0;
      out_mty1  <= next_out_mty1;
    end
  end

  // Straddle port map, segment 0 in the low half
  assign o_rx_data              = out_data;
  assign o_rx_valid             = out_valid;
  assign o_segment0_enable      = out_en[0];
  assign o_segment1_enable      = out_en[1];
  assign o_segment0_frame_start = out_sop[0];
  assign o_segment1_frame_start = out_sop[1];
  assign o_segment0_frame_end   = out_eop[0];
  assign o_segment1_frame_end   = out_eop[1];
  assign o_segment0_frame_bad   = out_err[0];
  assign o_segment1_frame_bad   = out_err[1];
  assign o_segment0_empty_bytes = out_mty0;
  assign o_segment1_empty_bytes = out_mty1;

  // ==========================================================================
  // Checks
  a_mty_zero_mid: assert property (@(posedge i_clk) disable iff (i_rst)
    (!out_eop[0] |-> out_mty0 == 3'h0) and (!out_eop[1] |-> out_mty1 == 3'h0))
    else $error("empty count nonzero outside frame end");

  a_valid_has_seg: assert property (@(posedge i_clk) disable iff (i_rst)
    out_valid |-> out_en != 2'h0)
    else $error("word valid without any segment enabled");

  a_enable_needs_valid: assert property (@(posedge i_clk) disable iff (i_rst)
    out_en != 2'h0 |-> out_valid)
    else $error("segment enable without word valid");

  a_flags_need_enable: assert property (@(posedge i_clk) disable iff (i_rst)
    ((out_sop | out_eop) & ~out_en) == 2'h0)
    else $error("start or end flag on disabled segment");

  a_bad_only_end: assert property (@(posedge i_clk) disable iff (i_rst)
    (out_err & ~out_eop) == 2'h0)
    else $error("bad flag outside frame end");

  a_fcs_marks_bad: assert property (@(posedge i_clk) disable iff (i_rst)
    (accept && i_seg_enable[0] && i_seg_end[0] && i_seg_fcs_bad[0] |-> push_err[0]) and
    (accept && i_seg_enable[1] && i_seg_end[1] && i_seg_fcs_bad[1] |-> push_err[1]))
    else $error("check sequence error not flagged");

  a_pop_goes_out: assert property (@(posedge i_clk) disable iff (i_rst)
    pop_fire |=> out_valid && out_data == $past(drain_bus.data[POS_DATA +: DATA_W]))
    else $error("popped word did not reach the client next cycle");

  a_drain_starts: assert property (@(posedge i_clk) disable iff (i_rst)
    state == DRAIN_WAIT && frames_held != 5'h00 |=> state == DRAIN_RUN ##1 out_valid)
    else $error("held frame not drained");

  a_reset_quiet: assert property (@(posedge i_clk)
    $past(i_rst) |-> !out_valid && out_en == 2'h0 && !fill_bus.ready)
    else $error("outputs active right after reset");

  a_code_sticks: assert property (@(posedge i_clk) disable iff (i_rst)
    accept && i_seg_enable[0] && i_seg_code_bad[0] && !(i_seg_enable[1] && i_seg_start[1])
    |=> code_sticky)
    else $error("code error not kept for the frame");

  a_held_in_buffer: assert property (@(posedge i_clk) disable iff (i_rst)
    frames_held != 5'h00 |-> drain_bus.valid)
    else $error("held frame end missing from buffer");

  // Output frame tracker for the checks below; segment 0 goes first
  logic                 out_open;
  logic                 next_out_open;
  logic                 mid_open;

  // A frame stays open from its start flag through its end flag
  always_comb begin
    mid_open = out_open;
    if (out_en[0]) begin
      mid_open = (out_sop[0] || out_open) && !out_eop[0];
    end
    next_out_open = mid_open;
    if (out_en[1]) begin
      next_out_open = (out_sop[1] || mid_open) && !out_eop[1];
    end
  end

  // Registered so each word is judged against the words before it
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      out_open <= 1'b0;
    end else begin
      out_open <= next_out_open;
    end
  end

  a_start_when_closed: assert property (@(posedge i_clk) disable iff (i_rst)
    (out_en[0] && out_sop[0] |-> !out_open) and (out_en[1] && out_sop[1] |-> !mid_open))
    else $error("frame start while a frame is open");

  a_data_in_frame: assert property (@(posedge i_clk) disable iff (i_rst)
    (out_en[0] && !out_sop[0] |-> out_open) and (out_en[1] && !out_sop[1] |-> mid_open))
    else $error("segment data outside any frame");
endmodule : rx_straddle_stream
`default_nettype wire

/* File: verilog/rx_stream_pkg.sv */
// Constants, field layout and state codes shared by the receive stream block
`default_nettype none
package rx_stream_pkg;
  // ==========================================================================
  // Bus geometry
  localparam int unsigned SEG_COUNT = 2;
  localparam int unsigned SEG_BYTES = 8;
  localparam int unsigned DATA_W    = 128;
  localparam int unsigned SEG_W     = 64;
  localparam int unsigned MTY_W     = 3;
  localparam int unsigned LEN_W     = 14;
  // ==========================================================================
  // Frame length limits in bytes, counted with the check sequence
  localparam logic [13:0] MIN_FRAME_BYTES = 14'h0040;
  localparam logic [13:0] MAX_FRAME_BYTES = 14'h05EE;
  localparam logic [13:0] LEN_SATURATE    = 14'h3FF0;
  localparam logic [13:0] SEG_BYTES_LEN   = 14'h0008;
  // ==========================================================================
  // Buffer sizing
  localparam int unsigned FIFO_DEPTH = 16;
  // ==========================================================================
  // Field positions inside one buffered word
  localparam int unsigned POS_DATA  = 0;
  localparam int unsigned POS_EN    = 128;
  localparam int unsigned POS_SOP   = 130;
  localparam int unsigned POS_EOP   = 132;
  localparam int unsigned POS_ERR   = 134;
  localparam int unsigned POS_MTY   = 136;
  localparam int unsigned WORD_W    = 142;
  // ==========================================================================
  // Reset values
  localparam logic [4:0] FRAMES_RESET = 5'h00;
  localparam logic [2:0] MTY_RESET    = 3'h0;
  // Drain sequencer states
  typedef enum logic [0:0] {
    DRAIN_WAIT = 1'b0,
    DRAIN_RUN  = 1'b1
  } drain_state_t;
endpackage : rx_stream_pkg
`default_nettype wire

/* File: verilog/word_stream_if.sv */
// Valid/ready word carrier between the receive block and its buffer
`default_nettype none
interface word_stream_if #(
  parameter int unsigned WIDTH = 8
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  // Producer side
  modport source (output valid, output data, input ready);
  // Consumer side
  modport sink   (input valid, input data, output ready);
endinterface : word_stream_if
`default_nettype wire

/* File: verilog/word_fifo.sv */
// Synchronous word FIFO with registered fill-side ready
`default_nettype none
module word_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic   i_clk,
  input  wire logic   i_rst,
  word_stream_if.sink   fill_side,
  word_stream_if.source drain_side
);
  localparam int unsigned PTR_W = $clog2(DEPTH);
  localparam int unsigned CNT_W = PTR_W + 1;
  localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_W-1:0] count;
  logic             fill_ready;
  logic [PTR_W-1:0] next_wr_ptr;
  logic [PTR_W-1:0] next_rd_ptr;
  logic [CNT_W-1:0] next_count;
  logic             next_fill_ready;
  logic             do_push;
  logic             do_pop;

  // ==========================================================================
  // Handshakes; ready is a flop so the block output never sees a comb path
  assign fill_side.ready  = fill_ready;
  assign drain_side.valid = (count != '0);
  assign drain_side.data  = mem[rd_ptr];
  assign do_push          = fill_side.valid && fill_ready;
  assign do_pop           = drain_side.valid && drain_side.ready;

  // Pointer and occupancy update
  always_comb begin
    next_wr_ptr     = do_push ? PTR_W'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr     = do_pop ? PTR_W'(rd_ptr + 1'b1) : rd_ptr;
    next_count      = CNT_W'(count + CNT_W'(do_push) - CNT_W'(do_pop));
    next_fill_ready = (next_count != FULL_COUNT);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_ptr     <= '0;
      rd_ptr     <= '0;
      count      <= '0;
      fill_ready <= 1'b0;
    end else begin
      wr_ptr     <= next_wr_ptr;
      rd_ptr     <= next_rd_ptr;
      count      <= next_count;
      fill_ready <= next_fill_ready;
    end
  end

  // Storage needs no reset; only written slots are ever read
  always_ff @(posedge i_clk) begin
    if (do_push) begin
      mem[wr_ptr] <= fill_side.data;
    end
  end
endmodule : word_fifo
`default_nettype wire

/* File: bench/rx_client_model.sv */
// Receive client model that gathers frames from the straddle stream
`default_nettype none
module rx_client_model (
  input wire logic                               i_clk,
  input wire logic                               i_rst,
  input wire logic [rx_stream_pkg::DATA_W-1:0]    i_data,
  input wire logic                               i_valid,
  input wire logic                               i_en0,
  input wire logic                               i_en1,
  input wire logic                               i_start0,
  input wire logic                               i_start1,
  input wire logic                               i_end0,
  input wire logic                               i_end1,
  input wire logic                               i_bad0,
  input wire logic                               i_bad1,
  input wire logic [rx_stream_pkg::MTY_W-1:0]     i_empty0,
  input wire logic [rx_stream_pkg::MTY_W-1:0]     i_empty1
);
  timeunit 1ns;
  timeprecision 1ps;
  import rx_stream_pkg::*;

  // ==========================================================================
  // Collected frames
  int          len_q[$];
  logic        bad_q[$];
  logic [63:0] head_q[$];
  int          gap_count;
  int          empty_fault;
  int          len;
  logic        in_frame;

  // One segment; bad flag only read at an enabled end, empty count checked for zero on other enabled segments
  task automatic take_seg(input logic en, input logic st, input logic ed, input logic bd,
                          input logic [MTY_W-1:0] mt, input logic [SEG_W-1:0] d);
    if (en === 1'b1 && i_valid === 1'b1) begin
      if (st === 1'b1) begin
        in_frame = 1'b1;
        len      = 0;
        head_q.push_back(d);
      end
      len += SEG_BYTES;
      if (ed === 1'b1) begin
        len -= int'(mt);
        len_q.push_back(len);
        bad_q.push_back(bd);
        in_frame = 1'b0;
      end else if (mt !== 3'h0) begin
        empty_fault++;
      end
    end
  endtask

  // Samples every rising edge, never stalls; segment 0 precedes segment 1
  always @(posedge i_clk) begin
    if (i_rst) begin
      in_frame = 1'b0;
    end else begin
      if (in_frame && i_valid !== 1'b1) begin
        gap_count++;
      end
      take_seg(i_en0, i_start0, i_end0, i_bad0, i_empty0, i_data[63:0]);
      take_seg(i_en1, i_start1, i_end1, i_bad1, i_empty1, i_data[127:64]);
    end
  end

  initial begin
    gap_count   = 0;
    empty_fault = 0;
    len         = 0;
    in_frame    = 1'b0;
  end
endmodule // rx_client_model
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the receive straddle stream block
`default_nettype none
`define CHECK(got, exp) begin check_count++; if ((got) !== (exp)) begin errors++; \
  $display("[FAIL] %0t mismatch got %0h exp %0h", $time, (got), (exp)); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import rx_stream_pkg::*;

  // ==========================================================================
  // Signals
  logic                 i_clk, i_rst, i_word_valid, o_in_ready, o_rx_valid;
  logic [DATA_W-1:0]    i_word_data, o_rx_data;
  logic [SEG_COUNT-1:0] i_seg_enable, i_seg_start, i_seg_end, i_seg_fcs_bad, i_seg_code_bad;
  logic [MTY_W-1:0]     i_seg0_empty, i_seg1_empty, o_segment0_empty_bytes, o_segment1_empty_bytes;
  logic                 o_segment0_enable, o_segment1_enable, o_segment0_frame_start;
  logic                 o_segment1_frame_start, o_segment0_frame_end, o_segment1_frame_end;
  logic                 o_segment0_frame_bad, o_segment1_frame_bad;
  int                   errors, check_count, cycles, seq;
  int                   exp_len[$];
  logic                 exp_bad[$];
  logic [63:0]          exp_head[$];

  rx_straddle_stream i_rx_straddle_stream (.i_clk, .i_rst, .i_word_data, .i_word_valid,
    .i_seg_enable, .i_seg_start, .i_seg_end, .i_seg0_empty, .i_seg1_empty, .i_seg_fcs_bad,
    .i_seg_code_bad, .o_in_ready, .o_rx_data, .o_rx_valid, .o_segment0_enable,
    .o_segment1_enable, .o_segment0_frame_start, .o_segment1_frame_start,
    .o_segment0_frame_end, .o_segment1_frame_end, .o_segment0_frame_bad,
    .o_segment1_frame_bad, .o_segment0_empty_bytes, .o_segment1_empty_bytes);

  rx_client_model i_rx_client_model (.i_clk(i_clk), .i_rst(i_rst), .i_data(o_rx_data),
    .i_valid(o_rx_valid), .i_en0(o_segment0_enable), .i_en1(o_segment1_enable),
    .i_start0(o_segment0_frame_start), .i_start1(o_segment1_frame_start),
    .i_end0(o_segment0_frame_end), .i_end1(o_segment1_frame_end),
    .i_bad0(o_segment0_frame_bad), .i_bad1(o_segment1_frame_bad),
    .i_empty0(o_segment0_empty_bytes), .i_empty1(o_segment1_empty_bytes));

  // ==========================================================================
  // Clock and hang guard
  always #12.5 i_clk = ~i_clk; // Free running

  // Longest run is a few hundred words; a hang trips far beyond that
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 6000) begin
      errors++;
      $display("[FAIL] %0t run did not finish", $time);
      close_out();
    end
  end

  // ==========================================================================
  // Drivers
  task automatic close_out();
    $display("Counts: %0d checks, %0d mismatches", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Offer one word at the falling edge and hold it until the buffer takes it
  task automatic put(input logic [1:0] en, input logic [1:0] st, input logic [1:0] ed,
                     input logic [2:0] e0, input logic [2:0] e1, input logic [1:0] fcs,
                     input logic [1:0] cb);
    int n;
    n = 0;
    @(negedge i_clk);
    i_word_valid   = 1'b1;
    i_seg_enable   = en;
    i_seg_start    = st;
    i_seg_end      = ed;
    i_seg0_empty   = e0;
    i_seg1_empty   = e1;
    i_seg_fcs_bad  = fcs;
    i_seg_code_bad = cb;
    i_word_data    = {64'(seq * 2 + 1), 64'(seq * 2)};
    if (st[0]) exp_head.push_back(64'(seq * 2));
    if (st[1]) exp_head.push_back(64'(seq * 2 + 1));
    while (o_in_ready !== 1'b1 && n < 200) begin
      @(negedge i_clk);
      n++;
    end
    if (n >= 200) begin
      errors++;
      $display("[FAIL] %0t buffer never ready", $time);
    end
    @(posedge i_clk);
    seq++;
  endtask

  task automatic idle();
    @(negedge i_clk);
    i_word_valid = 1'b0;
    i_seg_enable = 2'b00;
    i_seg_start  = 2'b00;
    i_seg_end    = 2'b00;
  endtask

  // Frame from segment 0 of nw words; expectation reckoned from length and errors
  task automatic frame(input int nw, input logic [1:0] last_en, input logic [2:0] emp,
                       input logic fcs, input logic code);
    int L;
    logic [1:0] ed;
    ed = (last_en == 2'b01) ? 2'b01 : 2'b10;
    L  = 16 * (nw - 1) + ((last_en == 2'b01) ? 8 : 16) - int'(emp);
    exp_len.push_back(L);
    exp_bad.push_back(fcs || code || L < int'(MIN_FRAME_BYTES) || L > int'(MAX_FRAME_BYTES));
    for (int w = 0; w < nw; w++) begin
      if (w == nw - 1)
        put(last_en, 2'b00, ed, (ed == 2'b01) ? emp : 3'h6, (ed == 2'b10) ? emp : 3'h6,
            fcs ? ed : 2'b00, 2'b00);
      else
        put(2'b11, (w == 0) ? 2'b01 : 2'b00, 2'b00, 3'h5, 3'h5, 2'b00,
            (code && w == 1) ? 2'b11 : 2'b00);
    end
  endtask

  // Wait for the client to collect every frame, then compare each one
  task automatic settle(input string name);
    int n;
    int gl;
    int el;
    logic gb;
    logic eb;
    logic [63:0] gh;
    logic [63:0] eh;
    n = 0;
    idle();
    while (i_rx_client_model.len_q.size() < exp_len.size() && n < 2000) begin
      @(posedge i_clk);
      n++;
    end
    repeat (4) @(posedge i_clk);
    `CHECK(i_rx_client_model.len_q.size(), exp_len.size())
    while (exp_len.size() > 0 && i_rx_client_model.len_q.size() > 0) begin
      gl = i_rx_client_model.len_q.pop_front();
      el = exp_len.pop_front();
      gb = i_rx_client_model.bad_q.pop_front();
      eb = exp_bad.pop_front();
      `CHECK(gl, el)
      `CHECK(gb, eb)
    end
    `CHECK(i_rx_client_model.head_q.size(), exp_head.size())
    while (exp_head.size() > 0 && i_rx_client_model.head_q.size() > 0) begin
      gh = i_rx_client_model.head_q.pop_front();
      eh = exp_head.pop_front();
      `CHECK(gh, eh)
    end
    `CHECK(i_rx_client_model.gap_count, 0)
    `CHECK(i_rx_client_model.empty_fault, 0)
    exp_len.delete();
    exp_bad.delete();
    exp_head.delete();
    $display("Test %s done, %0d mismatches so far", name, errors);
  endtask

  // ==========================================================================
  // Scenarios
  // Length limits on both sides, long frames outlast the buffer depth and stream through while draining already runs
  task automatic t_lengths();
    frame(4, 2'b11, 3'h0, 1'b0, 1'b0);
    frame(4, 2'b11, 3'h1, 1'b0, 1'b0);
    frame(95, 2'b11, 3'h2, 1'b0, 1'b0);
    frame(95, 2'b11, 3'h1, 1'b0, 1'b0);
    frame(5, 2'b01, 3'h7, 1'b0, 1'b0);
    settle("lengths");
  endtask

  task automatic t_errors();
    frame(4, 2'b11, 3'h0, 1'b1, 1'b0);
    frame(6, 2'b01, 3'h3, 1'b0, 1'b1);
    frame(5, 2'b01, 3'h0, 1'b1, 1'b0);
    settle("errors");
  endtask

  // Two frames share a word; the code error belongs to the second only
  task automatic t_straddle();
    put(2'b11, 2'b01, 2'b00, 3'h0, 3'h0, 2'b00, 2'b00);
    repeat (3) put(2'b11, 2'b00, 2'b00, 3'h0, 3'h0, 2'b00, 2'b00);
    put(2'b11, 2'b10, 2'b01, 3'h3, 3'h0, 2'b00, 2'b10);
    repeat (3) put(2'b11, 2'b00, 2'b00, 3'h0, 3'h0, 2'b00, 2'b00);
    put(2'b01, 2'b00, 2'b01, 3'h0, 3'h0, 2'b00, 2'b00);
    exp_len.push_back(69);
    exp_bad.push_back(1'b0);
    exp_len.push_back(64);
    exp_bad.push_back(1'b1);
    settle("straddle");
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    errors = 0;
    check_count = 0;
    cycles = 0;
    seq = 1;
    i_clk = 1'b0;
    i_rst = 1'b1;
    i_word_valid = 1'b0;
    i_word_data = '0;
    i_seg_enable = 2'b00;
    i_seg_start = 2'b00;
    i_seg_end = 2'b00;
    i_seg0_empty = 3'h0;
    i_seg1_empty = 3'h0;
    i_seg_fcs_bad = 2'b00;
    i_seg_code_bad = 2'b00;
    repeat (11) @(negedge i_clk);
    `CHECK(o_rx_valid, 1'b0)
    `CHECK(o_in_ready, 1'b0)
    @(negedge i_clk);
    i_rst = 1'b0;
    @(negedge i_clk);
    `CHECK(o_in_ready, 1'b1)
    $display("Test reset done, %0d mismatches so far", errors);
    t_lengths();
    t_errors();
    t_straddle();
    close_out();
  end
endmodule // testbench
`default_nettype wire
